// ==== rtl/csw_defines.svh ====
// Purpose: Offsets, field positions, reset values and codes for the status word block.
// Assumes: Byte addresses on an 8-bit AXI4-Lite address, one 32-bit word per register.
// Notes:   Definitions only; included by the package and the top module.
`ifndef CSW_DEFINES_SVH
`define CSW_DEFINES_SVH

`define CSW_AW              8
`define CSW_OFF_STATE       8'h00
`define CSW_OFF_SAVED_PC    8'h04
`define CSW_OFF_SAVED_STATE 8'h08
`define CSW_OFF_FLOAT       8'h0C
`define CSW_OFF_INT_STATUS  8'h10
`define CSW_OFF_INT_MASK    8'h14

`define CSW_BIT_C           0
`define CSW_BIT_Z           1
`define CSW_BIT_S           2
`define CSW_BIT_O           3
`define CSW_BIT_I           16
`define CSW_BIT_U           17
`define CSW_BIT_PM          20
`define CSW_IPL_LO          24
`define CSW_IPL_HI          27
`define CSW_STATE_WMASK     32'h0F13_000F
`define CSW_STATE_RST       32'h0000_0000

`define CSW_FBIT_OVF        0
`define CSW_FBIT_TRAP_EN    8
`define CSW_FLOAT_RST       32'h0000_0000

`define CSW_EV_IRQ          0
`define CSW_EV_EXC          1
`define CSW_EV_FPOVF        2
`define CSW_EV_N            3
`define CSW_EV_RST          3'h0

`define CSW_RESP_OKAY       2'h0
`define CSW_RESP_SLVERR     2'h2

`endif

// ==== rtl/csw_flag_calc.sv ====
// Purpose: Adder with carry, zero, sign and overflow results.
// Assumes: Subtraction is a plus inverted b plus one.
// Notes:   Carry on subtraction means no borrow occurred.
`timescale 1ns/1ps

module csw_flag_calc (
  input  wire csw_pkg::csw_word_t a,
  input  wire csw_pkg::csw_word_t b,
  input  wire logic               sub,
  output csw_pkg::csw_word_t      result,
  output logic                    carry,
  output logic                    zero,
  output logic                    sign,
  output logic                    ovf
);
  import csw_pkg::*;

  logic [32:0] sum;
  csw_word_t   b_eff;

  always_comb begin
    b_eff  = sub ? ~b : b;
    sum    = {1'b0, a} + {1'b0, b_eff} + {32'h0000_0000, sub};
    result = sum[31:0];
    carry  = sum[32];
    zero   = (sum[31:0] == 32'h0000_0000);
    sign   = sum[31];
    ovf    = (a[31] == b_eff[31]) && (sum[31] != a[31]);
  end
endmodule

// ==== rtl/csw_irq_gate.sv ====
// Purpose: Decides whether a presented interrupt request is taken.
// Assumes: Request and priority are stable, same-clock signals from the controller.
// Notes:   Purely combinational; the top registers the result.
`timescale 1ns/1ps

module csw_irq_gate (
  input  wire logic               req,
  input  wire csw_pkg::csw_prio_t prio,
  input  wire csw_pkg::csw_prio_t mask,
  input  wire logic               enable,
  input  wire logic               block,
  output logic                    take
);
  import csw_pkg::*;

  // A synchronous exception in the same cycle outranks any interrupt.
  always_comb begin
    take = req && enable && (prio > mask) && !block;
  end
endmodule

// ==== rtl/csw_pkg.sv ====
// Purpose: Types shared by the status word block and its helpers.
// Assumes: Constants come from csw_defines.svh.
// Notes:   Holds types only.
`include "csw_defines.svh"

package csw_pkg;
  typedef logic [31:0]          csw_word_t;
  typedef logic [3:0]           csw_prio_t;
  typedef logic [`CSW_AW-1:0]   csw_addr_t;
  typedef logic [`CSW_EV_N-1:0] csw_ev_t;
  typedef enum logic [1:0] {
    CSW_RD_IDLE = 2'b00,
    CSW_RD_RESP = 2'b01
  } csw_rd_state_t;
endpackage

// ==== rtl/csw_top.sv ====
// Purpose: Processor status word, interrupt gating and fast-interrupt backup.
// Assumes: Core and interrupt controller signals are on clk; registers over AXI4-Lite.
// Notes:   Hardware updates of the status word win over a software write in the same cycle.
//
// Our own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "csw_defines.svh"

module csw_top (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire csw_pkg::csw_addr_t s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire csw_pkg::csw_word_t s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire csw_pkg::csw_addr_t s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output csw_pkg::csw_word_t      s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire logic               alu_en,
  input  wire csw_pkg::csw_word_t alu_a,
  input  wire csw_pkg::csw_word_t alu_b,
  input  wire logic               alu_sub,
  input  wire logic               exc_req,
  input  wire logic               wait_accept,
  input  wire logic               to_user,
  input  wire logic               fast_return,
  input  wire csw_pkg::csw_word_t cur_pc,
  input  wire logic               fpu_ovf,
  input  wire logic               irq_req,
  input  wire csw_pkg::csw_prio_t irq_prio,
  input  wire logic               irq_fast,
  output logic                    irq_ack,
  output logic                    exc_accept,
  output logic                    fast_saved,
  output logic                    sp_task_sel,
  output logic                    user_mode,
  output csw_pkg::csw_word_t      state_word,
  output csw_pkg::csw_word_t      alu_result,
  output logic                    irq_out
);
  import csw_pkg::*;
  logic          aw_have_r, aw_have_nxt;
  logic          w_have_r, w_have_nxt;
  csw_addr_t     wa_r, wa_nxt;
  csw_word_t     wd_r, wd_nxt;
  logic [3:0]    ws_r, ws_nxt;
  logic          awready_r, awready_nxt;
  logic          wready_r, wready_nxt;
  logic          bvalid_r, bvalid_nxt;
  logic [1:0]    bresp_r, bresp_nxt;
  logic          wr_go, wr_hit;
  csw_rd_state_t rd_st_r, rd_st_nxt;
  logic          arready_r, arready_nxt;
  csw_word_t     rdata_r, rdata_nxt;
  logic [1:0]    rresp_r, rresp_nxt;
  csw_word_t     state_r, state_nxt;
  csw_word_t     spc_r, spc_nxt;
  csw_word_t     sst_r, sst_nxt;
  csw_word_t     float_r, float_nxt;
  csw_ev_t       ist_r, ist_nxt;
  csw_ev_t       imask_r, imask_nxt;
  logic          irq_d_r, irq_d_nxt;
  logic          ack_r, ack_nxt;
  logic          exc_r, exc_nxt;
  logic          fsv_r, fsv_nxt;
  logic          irqo_r, irqo_nxt;
  csw_word_t     res_r, res_nxt;
  csw_word_t     sum;
  logic          f_c, f_z, f_s, f_o;
  logic          fp_trap, irq_take, take_exc;
  csw_ev_t       ev_set;
  function automatic csw_word_t merge(input csw_word_t old, input csw_word_t nw,
                                      input logic [3:0] be);
    csw_word_t m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) m[i*8 +: 8] = nw[i*8 +: 8];
    end
    return m;
  endfunction
  function automatic logic mapped(input csw_addr_t a);
    return (a == `CSW_OFF_STATE) || (a == `CSW_OFF_SAVED_PC) ||
           (a == `CSW_OFF_SAVED_STATE) || (a == `CSW_OFF_FLOAT) ||
           (a == `CSW_OFF_INT_STATUS) || (a == `CSW_OFF_INT_MASK);
  endfunction
  csw_flag_calc i_csw_flag_calc (
    .a      (alu_a),
    .b      (alu_b),
    .sub    (alu_sub),
    .result (sum),
    .carry  (f_c),
    .zero   (f_z),
    .sign   (f_s),
    .ovf    (f_o)
  );
  csw_irq_gate i_csw_irq_gate (
    .req    (irq_req),
    .prio   (irq_prio),
    .mask   (state_r[`CSW_IPL_HI:`CSW_IPL_LO]),
    .enable (state_r[`CSW_BIT_I]),
    .block  (exc_req || fp_trap),
    .take   (irq_take)
  );

  // Bus write channel: address and data may arrive in either order.
  always_comb begin
    aw_have_nxt = aw_have_r;
    w_have_nxt  = w_have_r;
    wa_nxt      = wa_r;
    wd_nxt      = wd_r;
    ws_nxt      = ws_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    wr_go       = aw_have_r && w_have_r && !bvalid_r;
    wr_hit      = wr_go && mapped(wa_r);
    if (s_axi_awvalid && awready_r) begin
      aw_have_nxt = 1'b1;
      wa_nxt      = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_have_nxt = 1'b1;
      wd_nxt     = s_axi_wdata;
      ws_nxt     = s_axi_wstrb;
    end
    if (wr_go) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = mapped(wa_r) ? `CSW_RESP_OKAY : `CSW_RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    awready_nxt = !aw_have_nxt && !bvalid_nxt;
    wready_nxt  = !w_have_nxt && !bvalid_nxt;
  end
  // Bus read channel: one read at a time, answered one cycle after it is taken.
  always_comb begin
    rd_st_nxt   = rd_st_r;
    arready_nxt = (rd_st_r == CSW_RD_IDLE);
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    case (rd_st_r)
      CSW_RD_IDLE: begin
        if (s_axi_arvalid && arready_r) begin
          rd_st_nxt   = CSW_RD_RESP;
          arready_nxt = 1'b0;
          rresp_nxt   = mapped(s_axi_araddr) ? `CSW_RESP_OKAY : `CSW_RESP_SLVERR;
          case (s_axi_araddr)
            `CSW_OFF_STATE:       rdata_nxt = state_r;
            `CSW_OFF_SAVED_PC:    rdata_nxt = spc_r;
            `CSW_OFF_SAVED_STATE: rdata_nxt = sst_r;
            `CSW_OFF_FLOAT:       rdata_nxt = float_r;
            `CSW_OFF_INT_STATUS:  rdata_nxt = {29'h0000_0000, ist_r};
            `CSW_OFF_INT_MASK:    rdata_nxt = {29'h0000_0000, imask_r};
            default:              rdata_nxt = 32'h0000_0000;
          endcase
        end
      end
      CSW_RD_RESP: begin
        if (s_axi_rready) begin
          rd_st_nxt   = CSW_RD_IDLE;
          arready_nxt = 1'b1;
        end
      end
      default: begin
        rd_st_nxt   = CSW_RD_IDLE;
        arready_nxt = 1'b1;
      end
    endcase
  end

  // Status word, backups, float status and interrupt mask register.
  always_comb begin
    fp_trap   = fpu_ovf && float_r[`CSW_FBIT_TRAP_EN];
    take_exc  = exc_req || fp_trap || irq_take;
    state_nxt = state_r;
    spc_nxt   = spc_r;
    sst_nxt   = sst_r;
    float_nxt = float_r;
    imask_nxt = imask_r;
    res_nxt   = res_r;
    if (wr_hit && wa_r == `CSW_OFF_STATE) begin
      state_nxt = merge(state_r, wd_r, ws_r) & `CSW_STATE_WMASK;
    end
    if (wr_hit && wa_r == `CSW_OFF_FLOAT) begin
      float_nxt = merge(float_r, wd_r, ws_r);
      float_nxt[31:9] = 23'h00_0000;
      float_nxt[7:1]  = 7'h00;
    end
    if (wr_hit && wa_r == `CSW_OFF_INT_MASK && ws_r[0]) begin
      imask_nxt = wd_r[`CSW_EV_N-1:0];
    end
    if (fpu_ovf) begin
      float_nxt[`CSW_FBIT_OVF] = 1'b1;
    end
    if (alu_en) begin
      res_nxt              = sum;
      state_nxt[`CSW_BIT_C] = f_c;
      state_nxt[`CSW_BIT_Z] = f_z;
      state_nxt[`CSW_BIT_S] = f_s;
      state_nxt[`CSW_BIT_O] = f_o;
    end
    if (wait_accept) begin
      state_nxt[`CSW_BIT_I] = 1'b1;
    end
    if (to_user) begin
      state_nxt[`CSW_BIT_U]  = 1'b1;
      state_nxt[`CSW_BIT_PM] = 1'b1;
    end
    if (fast_return) begin
      state_nxt = sst_r;
    end
    if (take_exc) begin
      // All three bits move in the one cycle so no handler sees a mixed state.
      state_nxt[`CSW_BIT_I]  = 1'b0;
      state_nxt[`CSW_BIT_U]  = 1'b0;
      state_nxt[`CSW_BIT_PM] = 1'b0;
    end
    if (irq_take && irq_fast) begin
      spc_nxt = cur_pc;
      sst_nxt = state_r;
    end
  end

  // Interrupt events: arrival is recorded whatever the enable flag says.
  always_comb begin
    irq_d_nxt               = irq_req;
    ev_set                  = `CSW_EV_RST;
    ev_set[`CSW_EV_IRQ]     = irq_req && !irq_d_r;
    ev_set[`CSW_EV_EXC]     = take_exc;
    ev_set[`CSW_EV_FPOVF]   = fpu_ovf;
    ist_nxt                 = ist_r;
    if (wr_hit && wa_r == `CSW_OFF_INT_STATUS && ws_r[0]) begin
      ist_nxt = ist_r & ~wd_r[`CSW_EV_N-1:0];
    end
    ist_nxt  = ist_nxt | ev_set;
    irqo_nxt = |(ist_nxt & imask_nxt);
    ack_nxt  = irq_take;
    exc_nxt  = take_exc;
    fsv_nxt  = irq_take && irq_fast;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      wa_r      <= '0;
      wd_r      <= 32'h0000_0000;
      ws_r      <= 4'h0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `CSW_RESP_OKAY;
      rd_st_r   <= CSW_RD_IDLE;
      arready_r <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= `CSW_RESP_OKAY;
      state_r   <= `CSW_STATE_RST;
      spc_r     <= 32'h0000_0000;
      sst_r     <= 32'h0000_0000;
      float_r   <= `CSW_FLOAT_RST;
      ist_r     <= `CSW_EV_RST;
      imask_r   <= `CSW_EV_RST;
      irq_d_r   <= 1'b0;
      ack_r     <= 1'b0;
      exc_r     <= 1'b0;
      fsv_r     <= 1'b0;
      irqo_r    <= 1'b0;
      res_r     <= 32'h0000_0000;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r  <= w_have_nxt;
      wa_r      <= wa_nxt;
      wd_r      <= wd_nxt;
      ws_r      <= ws_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rd_st_r   <= rd_st_nxt;
      arready_r <= arready_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
      state_r   <= state_nxt;
      spc_r     <= spc_nxt;
      sst_r     <= sst_nxt;
      float_r   <= float_nxt;
      ist_r     <= ist_nxt;
      imask_r   <= imask_nxt;
      irq_d_r   <= irq_d_nxt;
      ack_r     <= ack_nxt;
      exc_r     <= exc_nxt;
      fsv_r     <= fsv_nxt;
      irqo_r    <= irqo_nxt;
      res_r     <= res_nxt;
    end
  end
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rvalid  = rd_st_r[0]; // Only the response state has bit 0 set.
  assign irq_ack       = ack_r;
  assign exc_accept    = exc_r;
  assign fast_saved    = fsv_r;
  assign sp_task_sel   = state_r[`CSW_BIT_U];
  assign user_mode     = state_r[`CSW_BIT_PM];
  assign state_word    = state_r;
  assign alu_result    = res_r;
  assign irq_out       = irqo_r;
endmodule

// ==== verif/csw_irq_ctrl_model.sv ====
// Purpose: Interrupt controller model presenting one request at a time.
// Assumes: Bench posts a request with a priority, a fast flag and a lag.
// Notes:   Released lines show inverted values so stale data is never trusted.
`timescale 1ns/1ps

module csw_irq_ctrl_model (
  input wire logic               clk,
  input wire logic               rst,
  input wire logic               post,
  input wire csw_pkg::csw_prio_t post_prio,
  input wire logic               post_fast,
  input wire logic [3:0]         lag,
  input wire logic               drop,
  input wire logic               irq_ack,
  output logic                   irq_req,
  output csw_pkg::csw_prio_t     irq_prio,
  output logic                   irq_fast
);
  logic [3:0] wait_r;
  logic       pend_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_req  <= 1'h0;
      irq_prio <= 4'hF;
      irq_fast <= 1'h0;
      pend_r   <= 1'h0;
      wait_r   <= 4'h0;
    end else if (post) begin
      pend_r   <= 1'h1;
      wait_r   <= lag;
      irq_prio <= post_prio;
      irq_fast <= post_fast;
    end else if (pend_r && wait_r == 4'h0) begin
      irq_req <= 1'h1;
      pend_r  <= 1'h0;
    end else if (pend_r) begin
      wait_r <= wait_r - 4'h1;
    end else if (irq_ack || drop) begin
      irq_req  <= 1'h0;
      irq_prio <= ~irq_prio;
      irq_fast <= ~irq_fast;
    end
  end
endmodule

// ==== verif/csw_top_assertions.sv ====
// Purpose: Port-level checks of the status word block.
// Assumes: One clock; synchronous active-high reset.
// Notes:   Bound to the top module from the testbench file.
`timescale 1ns/1ps
`include "csw_defines.svh"

module csw_top_assertions
  import csw_pkg::*;
(
  input wire logic               clk,
  input wire logic               rst,
  input wire csw_pkg::csw_word_t alu_a,
  input wire csw_pkg::csw_word_t alu_b,
  input wire logic               alu_en,
  input wire logic               alu_sub,
  input wire logic               exc_req,
  input wire logic               wait_accept,
  input wire logic               to_user,
  input wire logic               fast_return,
  input wire logic               fpu_ovf,
  input wire logic               irq_req,
  input wire csw_pkg::csw_prio_t irq_prio,
  input wire logic               irq_fast,
  input wire logic               irq_ack,
  input wire logic               exc_accept,
  input wire logic               fast_saved,
  input wire logic               sp_task_sel,
  input wire logic               user_mode,
  input wire csw_pkg::csw_word_t state_word
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [32:0] sum_w;
  logic        quiet_w;
  csw_prio_t   ipl_w;
  assign sum_w   = {1'h0, alu_a} + {1'h0, alu_b};
  assign quiet_w = !exc_req && !irq_req && !fpu_ovf && !fast_return;
  assign ipl_w   = state_word[`CSW_IPL_HI:`CSW_IPL_LO];

  property p_reset_clear;
    $fell(rst) |-> state_word == 32'h0000_0000;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("word not clear after reset");
  property p_add_flags;
    alu_en && !alu_sub && !fast_return |=> state_word[`CSW_BIT_C] == $past(sum_w[32])
      && state_word[`CSW_BIT_Z] == ($past(sum_w[31:0]) == 32'h0000_0000);
  endproperty
  a_add_flags: assert property (p_add_flags)
    else $error("add flags wrong");
  property p_exc_enable;
    exc_req |=> exc_accept && !state_word[`CSW_BIT_I];
  endproperty
  a_exc_enable: assert property (p_exc_enable)
    else $error("exception left enable set");
  property p_exc_mode;
    exc_req |=> !user_mode && !sp_task_sel && !state_word[`CSW_BIT_I];
  endproperty
  a_exc_mode: assert property (p_exc_mode)
    else $error("exception left user state");
  property p_wait_enable;
    wait_accept && quiet_w |=> state_word[`CSW_BIT_I];
  endproperty
  a_wait_enable: assert property (p_wait_enable)
    else $error("wait did not enable");
  property p_user_switch;
    to_user && quiet_w |=> user_mode && sp_task_sel;
  endproperty
  a_user_switch: assert property (p_user_switch)
    else $error("user switch wrong");
  property p_refuse;
    irq_req && (!state_word[`CSW_BIT_I] || irq_prio <= ipl_w) |=> !irq_ack;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("request taken when refused");
  property p_take;
    irq_req && state_word[`CSW_BIT_I] && irq_prio > ipl_w && !exc_req && !fpu_ovf
      |=> irq_ack && exc_accept && fast_saved == $past(irq_fast);
  endproperty
  a_take: assert property (p_take)
    else $error("request not taken");
  property p_ports_mirror;
    exc_accept |-> !user_mode && !sp_task_sel && !state_word[`CSW_BIT_PM]
      && !state_word[`CSW_BIT_U] && !state_word[`CSW_BIT_I];
  endproperty
  a_ports_mirror: assert property (p_ports_mirror)
    else $error("state not cleared with exception");

  c_fast: cover property (irq_ack && fast_saved);
  c_exc: cover property (exc_req ##1 exc_accept);
  c_user: cover property (to_user ##1 user_mode);
endmodule

// ==== verif/csw_top_test.sv ====
// Purpose: Self-checking bench for the status word block.
// Assumes: 20 MHz clock; AXI4-Lite master tasks; controller model on the far side.
// Notes:   Each scenario task drives the block and judges the outcome itself.
`timescale 1ns/1ps
`include "csw_defines.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end

module csw_top_test;
  import csw_pkg::*;
  logic       clk = 1'h0;
  logic       rst = 1'h1;
  csw_addr_t  s_axi_awaddr = '0, s_axi_araddr = '0;
  csw_word_t  s_axi_wdata = '0, alu_a = '0, alu_b = '0, cur_pc = '0;
  logic [3:0] s_axi_wstrb = 4'hF, lag = 4'h0;
  csw_prio_t  post_prio = 4'h0;
  logic       s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic       s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, alu_en = 1'h0, alu_sub = 1'h0;
  logic       exc_req = 1'h0, wait_accept = 1'h0, to_user = 1'h0, fast_return = 1'h0;
  logic       fpu_ovf = 1'h0, post = 1'h0, post_fast = 1'h0, drop = 1'h0;
  logic       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic       irq_req, irq_fast, irq_ack, exc_accept, fast_saved, sp_task_sel;
  logic       user_mode, irq_out;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  csw_word_t  s_axi_rdata, state_word, alu_result;
  csw_prio_t  irq_prio;
  int         err_total = 0, samples_checked = 0, cycles = 0;

  csw_top i_csw_top (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .alu_en, .alu_a, .alu_b, .alu_sub, .exc_req, .wait_accept, .to_user,
    .fast_return, .cur_pc, .fpu_ovf, .irq_req, .irq_prio, .irq_fast, .irq_ack, .exc_accept,
    .fast_saved, .sp_task_sel, .user_mode, .state_word, .alu_result, .irq_out);
  csw_irq_ctrl_model i_csw_irq_ctrl_model (.clk, .rst, .post, .post_prio, .post_fast, .lag,
    .drop, .irq_ack, .irq_req, .irq_prio, .irq_fast);

  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      err_total++;
      stop_test();
    end
  end

  task automatic stop_test;
    if (err_total == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic axw(input csw_addr_t a, input csw_word_t d, input logic [1:0] r);
    logic ad = 1'h0;
    logic dd = 1'h0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) begin
        ad = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        dd = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    `CHK("bresp", r, s_axi_bresp)
  endtask

  task automatic axr(input csw_addr_t a, input csw_word_t d, input logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    `CHK("rdata", d, s_axi_rdata)
    `CHK("rresp", r, s_axi_rresp)
  endtask

  // Bits of v, high to low: exc_req, wait_accept, to_user, fast_return, fpu_ovf.
  task automatic pulse(input logic [4:0] v);
    @(posedge clk);
    {exc_req, wait_accept, to_user, fast_return, fpu_ovf} <= v;
    @(posedge clk);
    {exc_req, wait_accept, to_user, fast_return, fpu_ovf} <= 5'h00;
    #1;
  endtask

  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // A refused request is withdrawn by the controller so the next offer starts clean.
  task automatic offer(input csw_prio_t p, input logic f, input logic [3:0] l, input logic e);
    logic [2:0] got = 3'h0;
    @(posedge clk);
    post <= 1'h1;
    post_prio <= p;
    post_fast <= f;
    lag <= l;
    @(posedge clk);
    post <= 1'h0;
    repeat (10) begin
      @(posedge clk);
      #1;
      if (irq_ack) got = {1'h1, exc_accept, fast_saved};
    end
    `CHK("take", {e, e, e & f}, got)
    @(posedge clk);
    drop <= 1'h1;
    @(posedge clk);
    drop <= 1'h0;
  endtask

  task automatic t_reset_gate;
    `CHK("word", 32'h0000_0000, state_word)
    axr(`CSW_OFF_STATE, 32'h0000_0000, `CSW_RESP_OKAY);
    offer(4'h9, 1'h0, 4'h0, 1'h0);
    axr(`CSW_OFF_INT_STATUS, 32'h0000_0001, `CSW_RESP_OKAY);
    axw(`CSW_OFF_INT_STATUS, 32'h0000_0001, `CSW_RESP_OKAY);
    axr(`CSW_OFF_INT_STATUS, 32'h0000_0000, `CSW_RESP_OKAY);
    axr(8'h40, 32'h0000_0000, `CSW_RESP_SLVERR);
    axw(8'h40, 32'hFFFF_FFFF, `CSW_RESP_SLVERR);
    s_axi_wstrb <= 4'h1;
    axw(`CSW_OFF_STATE, 32'hFFFF_FFFF, `CSW_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    axr(`CSW_OFF_STATE, 32'h0000_000F, `CSW_RESP_OKAY);
  endtask

  task automatic t_alu;
    csw_word_t  a [6] = '{32'hFFFF_FFFF, 32'h7FFF_FFFF, 32'h5, 32'h3, 32'h5, 32'h8000_0000};
    csw_word_t  b [6] = '{32'h1, 32'h1, 32'h3, 32'h5, 32'h5, 32'h1};
    logic [3:0] f [6] = '{4'h3, 4'hC, 4'h0, 4'h4, 4'h3, 4'h9};
    csw_word_t  r [6] = '{32'h0, 32'h8000_0000, 32'h8, 32'hFFFF_FFFE, 32'h0, 32'h7FFF_FFFF};
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      alu_a <= a[i];
      alu_b <= b[i];
      alu_sub <= (i > 2);
      alu_en <= 1'h1;
      @(posedge clk);
      alu_en <= 1'h0;
      #1;
      `CHK("flags", f[i], state_word[3:0])
      `CHK("result", r[i], alu_result)
    end
  endtask

  task automatic t_mask;
    axw(`CSW_OFF_STATE, 32'h0F01_0000, `CSW_RESP_OKAY);
    offer(4'hF, 1'h0, 4'h0, 1'h0);
    axw(`CSW_OFF_STATE, 32'h0501_0000, `CSW_RESP_OKAY);
    offer(4'h5, 1'h0, 4'h0, 1'h0);
    offer(4'h6, 1'h0, 4'h3, 1'h1);
    `CHK("word", 32'h0500_0000, state_word)
  endtask

  task automatic t_mode;
    axw(`CSW_OFF_STATE, 32'h0000_0000, `CSW_RESP_OKAY);
    pulse(5'h08);
    `CHK("enable", 1'h1, state_word[`CSW_BIT_I])
    pulse(5'h04);
    `CHK("user", 2'h3, {user_mode, sp_task_sel})
    `CHK("user_bits", 2'h3, {state_word[20], state_word[17]})
    pulse(5'h10);
    `CHK("exc", 2'h2, {exc_accept, state_word[16]})
    `CHK("exc_mode", 2'h0, {state_word[17], state_word[20]})
    `CHK("exc_ports", 2'h0, {sp_task_sel, user_mode})
  endtask

  task automatic t_fast;
    @(posedge clk);
    cur_pc <= 32'h0000_1234;
    axw(`CSW_OFF_STATE, 32'h0301_000F, `CSW_RESP_OKAY);
    offer(4'h5, 1'h1, 4'h1, 1'h1);
    axr(`CSW_OFF_SAVED_PC, 32'h0000_1234, `CSW_RESP_OKAY);
    axr(`CSW_OFF_SAVED_STATE, 32'h0301_000F, `CSW_RESP_OKAY);
    pulse(5'h02);
    `CHK("restore", 32'h0301_000F, state_word)
  endtask

  task automatic t_float;
    axw(`CSW_OFF_INT_MASK, 32'h0000_0004, `CSW_RESP_OKAY);
    axw(`CSW_OFF_INT_STATUS, 32'h0000_0003, `CSW_RESP_OKAY);
    pulse(5'h01);
    settle();
    `CHK("irq_out", 1'h1, irq_out)
    axr(`CSW_OFF_FLOAT, 32'h0000_0001, `CSW_RESP_OKAY);
    axr(`CSW_OFF_INT_STATUS, 32'h0000_0004, `CSW_RESP_OKAY);
    axw(`CSW_OFF_INT_MASK, 32'h0000_0000, `CSW_RESP_OKAY);
    settle();
    `CHK("masked", 1'h0, irq_out)
    axw(`CSW_OFF_INT_STATUS, 32'h0000_0004, `CSW_RESP_OKAY);
    axw(`CSW_OFF_INT_MASK, 32'h0000_0004, `CSW_RESP_OKAY);
    settle();
    `CHK("cleared", 1'h0, irq_out)
    axw(`CSW_OFF_FLOAT, 32'h0000_0100, `CSW_RESP_OKAY);
    pulse(5'h01);
    `CHK("trap", 1'h1, exc_accept)
  endtask

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    t_reset_gate();
    t_alu();
    t_mask();
    t_mode();
    t_fast();
    t_float();
    stop_test();
  end
endmodule

bind csw_top csw_top_assertions i_csw_top_assertions (.clk, .rst, .alu_a, .alu_b, .alu_en,
  .alu_sub, .exc_req, .wait_accept, .to_user, .fast_return, .fpu_ovf, .irq_req, .irq_prio,
  .irq_fast, .irq_ack, .exc_accept, .fast_saved, .sp_task_sel, .user_mode, .state_word);
